// *** src/glyph_pkg.sv ***
// shared constants, enums and carrier structs for the user glyph pattern ram
package glyph_pkg;

    // storage geometry: 64 rows of 8 bits
    localparam int unsigned ADDR_W    = 6;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned DEPTH     = 64;
    localparam int unsigned DOT_W     = 5;   // bits that reach the dot drivers
    localparam int unsigned CODE_W    = 8;   // character code width
    localparam int unsigned ROW_W     = 4;   // display row index width

    // row field widths per font
    localparam int unsigned ROW7_W    = 3;
    localparam int unsigned ROW10_W   = 4;
    localparam int unsigned SLOT7_W   = 3;   // eight patterns in 5x7
    localparam int unsigned SLOT10_W  = 2;   // four patterns in 5x10

    // code fields
    localparam int unsigned CODE_HI_LSB   = 4;   // upper nibble start
    localparam int unsigned CODE_HI_W     = 4;
    localparam logic [3:0]  CODE_HI_RAM   = 4'h0; // upper nibble that picks the ram
    localparam int unsigned SLOT10_LSB    = 1;   // code bits 2:1 in 5x10

    // cursor rows and last shown row
    localparam logic [2:0]  CURSOR_ROW_7  = 3'h7;
    localparam logic [3:0]  CURSOR_ROW_10 = 4'ha;
    localparam logic [3:0]  LAST_ROW_10   = 4'ha;

    // address step and reset values
    localparam logic [5:0]  ADDR_STEP     = 6'h01;
    localparam logic [5:0]  ADDR_RST      = 6'h00;
    localparam logic [7:0]  DATA_RST      = 8'h00;
    localparam logic [4:0]  DOTS_OFF      = 5'h00;
    localparam logic [4:0]  DOTS_ALL      = 5'h1f;

    // font selection
    typedef enum logic {
        FONT_5X7,
        FONT_5X10
    } font_e;

    // host access request from the instruction logic
    typedef struct packed {
        logic        load;      // load start address
        logic        dir_up;    // step direction taken on load
        logic [5:0]  addr;      // start address
        logic        wr;        // write one row
        logic        rd;        // read one row
        logic [7:0]  data;      // host data bus value for a write
    } host_req_s;

    // host read answer
    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
    } host_rsp_s;

    // display fetch request
    typedef struct packed {
        logic        req;
        logic [7:0]  code;      // character code from the text ram
        logic [3:0]  row;       // row being scanned
        logic        cursor;    // cursor shown on this character
    } disp_req_s;

    // display fetch answer
    typedef struct packed {
        logic        valid;
        logic        ram_sel;   // pattern comes from the glyph ram
        logic [4:0]  dots;      // dot pattern, bit high lights the dot
    } disp_rsp_s;

endpackage

// *** src/glyph_mem.sv ***
// 64 x 8 glyph storage, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none

module glyph_mem
(
    input  wire logic                          mclk_i,
    input  wire logic                          rst_b_i,
    input  wire logic                          wr_en_i,
    input  wire logic [glyph_pkg::ADDR_W-1:0]  wr_addr_i,
    input  wire logic [glyph_pkg::DATA_W-1:0]  wr_data_i,
    input  wire logic [glyph_pkg::ADDR_W-1:0]  rd_a_addr_i,
    output var  logic [glyph_pkg::DATA_W-1:0]  rd_a_data_o,
    input  wire logic [glyph_pkg::ADDR_W-1:0]  rd_b_addr_i,
    output var  logic [glyph_pkg::DATA_W-1:0]  rd_b_data_o
);
    import glyph_pkg::*;

    // storage array, no reset: contents are undefined until written
    logic [DATA_W-1:0] mem_reg [0:DEPTH-1];

    ////////////////////////////////////////////////////////////////////////
    // write port, all eight bits stored
    always_ff @(posedge mclk_i)
    begin
        if (wr_en_i)
        begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read ports sample every cycle; same-address write returns old data
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            rd_a_data_o <= DATA_RST;
            rd_b_data_o <= DATA_RST;
        end
        else
        begin
            rd_a_data_o <= mem_reg[rd_a_addr_i];
            rd_b_data_o <= mem_reg[rd_b_addr_i];
        end
    end

endmodule

`default_nettype wire

// *** src/user_glyph_pattern_ram.sv ***
// user glyph pattern ram: host row access with stepping address, display fetch
`timescale 1ns/1ps
`default_nettype none

module user_glyph_pattern_ram
(
    input  wire logic                  mclk_i,    // 40 MHz controller clock
    input  wire logic                  rst_b_i,   // synchronous reset, active low
    input  wire glyph_pkg::font_e      font_i,    // font mode from instruction logic
    input  wire glyph_pkg::host_req_s  host_i,    // host access request
    output var  glyph_pkg::host_rsp_s  host_o,    // host read answer
    output var  logic [glyph_pkg::ADDR_W-1:0] addr_o, // current address counter
    input  wire glyph_pkg::disp_req_s  disp_i,    // display fetch request
    output var  glyph_pkg::disp_rsp_s  disp_o     // display fetch answer
);
    import glyph_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [ADDR_W-1:0] addr_reg;        // host address counter
    logic [ADDR_W-1:0] addr_next;       // its next value
    logic              dir_up_reg;      // step direction, high counts up
    logic              access;          // a host row access this cycle
    logic              rd_pend_reg;     // host read data due next cycle

    logic [DATA_W-1:0] host_q;          // host read port data
    logic [DATA_W-1:0] disp_q;          // display read port data

    logic [ADDR_W-1:0] disp_addr;       // fetch address from code and row
    logic              disp_ram_hit;    // code maps onto the glyph ram

    // pipeline stage between fetch request and answer
    logic              p1_valid_reg;    // fetch in flight
    logic              p1_ram_reg;      // fetch reads the glyph ram
    logic              p1_cursor_reg;   // this row is lit by the cursor
    logic              p1_shown_reg;    // this row reaches the dots at all

    logic              cursor_row;      // requested row is the cursor row
    logic              shown_row;       // requested row is a displayed row
    logic [DOT_W-1:0]  dots_next;       // dot answer before its register

    ////////////////////////////////////////////////////////////////////////
    // storage: host port a, display port b
    glyph_mem u_mem
    (
        .mclk_i      (mclk_i),
        .rst_b_i     (rst_b_i),
        .wr_en_i     (host_i.wr & ~host_i.load),
        .wr_addr_i   (addr_reg),
        .wr_data_i   (host_i.data),
        .rd_a_addr_i (addr_reg),
        .rd_a_data_o (host_q),
        .rd_b_addr_i (disp_addr),
        .rd_b_data_o (disp_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // host address counter

    // a load takes priority; a write or read in the same cycle is dropped,
    // since the host is expected to load first and access afterwards
    assign access = (host_i.wr | host_i.rd) & ~host_i.load;

    // next address: load, step by one on any access, or hold
    always_comb
    begin
        addr_next = addr_reg;
        if (host_i.load)
        begin
            addr_next = host_i.addr;
        end
        else if (access)
        begin
            // wraps around the 64-row space in both directions
            if (dir_up_reg)
            begin
                addr_next = addr_reg + ADDR_STEP;
            end
            else
            begin
                addr_next = addr_reg - ADDR_STEP;
            end
        end
    end

    // counter register, also the step for reads
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            addr_reg <= ADDR_RST;
        end
        else
        begin
            addr_reg <= addr_next;
        end
    end

    // direction is taken with the address load
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            dir_up_reg <= 1'b1;     // count up after reset
        end
        else if (host_i.load)
        begin
            dir_up_reg <= host_i.dir_up;
        end
    end

    // address visible to the instruction logic
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            addr_o <= ADDR_RST;
        end
        else
        begin
            addr_o <= addr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host read answer

    // a read started this cycle has its data at port a one edge later
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            rd_pend_reg <= 1'b0;
        end
        else
        begin
            rd_pend_reg <= host_i.rd & ~host_i.wr & ~host_i.load;
        end
    end

    // all eight bits returned, including the never-shown upper ones
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            host_o.valid <= 1'b0;
            host_o.data  <= DATA_RST;
        end
        else
        begin
            host_o.valid <= rd_pend_reg;
            if (rd_pend_reg)
            begin
                host_o.data <= host_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // display fetch address

    // ram is picked by a zero upper nibble of the code
    assign disp_ram_hit = (disp_i.code[CODE_HI_LSB +: CODE_HI_W] == CODE_HI_RAM);

    // code bits that are ignored in each font simply never reach the address
    always_comb
    begin
        disp_addr = ADDR_RST;
        case (font_i)
            FONT_5X7:
            begin
                // code 2:0 above row 2:0, code bit 3 dropped
                disp_addr = {disp_i.code[SLOT7_W-1:0],
                             disp_i.row[ROW7_W-1:0]};
            end
            FONT_5X10:
            begin
                // code 2:1 above row 3:0, code bits 0 and 3 dropped
                disp_addr = {disp_i.code[SLOT10_LSB +: SLOT10_W],
                             disp_i.row[ROW10_W-1:0]};
            end
            default:
            begin
                disp_addr = ADDR_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // row classification

    // cursor row and displayed rows depend on the font
    always_comb
    begin
        cursor_row = 1'b0;
        shown_row  = 1'b0;
        case (font_i)
            FONT_5X7:
            begin
                cursor_row = (disp_i.row[ROW7_W-1:0] == CURSOR_ROW_7);
                shown_row  = 1'b1;  // all eight rows reach the dots
            end
            FONT_5X10:
            begin
                cursor_row = (disp_i.row == CURSOR_ROW_10);
                shown_row  = (disp_i.row <= LAST_ROW_10);
            end
            default:
            begin
                cursor_row = 1'b0;
                shown_row  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch pipeline stage, aligned with the registered read of port b

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            p1_valid_reg  <= 1'b0;
            p1_ram_reg    <= 1'b0;
            p1_cursor_reg <= 1'b0;
            p1_shown_reg  <= 1'b0;
        end
        else
        begin
            p1_valid_reg  <= disp_i.req;
            p1_ram_reg    <= disp_i.req & disp_ram_hit;
            p1_cursor_reg <= disp_i.req & disp_i.cursor & cursor_row;
            p1_shown_reg  <= disp_i.req & shown_row;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dot pattern

    // only bits 4:0 reach the dots; a row outside the shown range stays
    // dark even under the cursor, since no common line scans it
    always_comb
    begin
        dots_next = DOTS_OFF;
        if (p1_ram_reg && p1_shown_reg)
        begin
            dots_next = disp_q[DOT_W-1:0];
            if (p1_cursor_reg)
            begin
                // the host keeps these bits low so the cursor stands out
                dots_next = dots_next | DOTS_ALL;
            end
        end
    end

    // answer register; rom codes answer with ram_sel low and dark dots,
    // the rom path outside supplies those patterns
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            disp_o.valid   <= 1'b0;
            disp_o.ram_sel <= 1'b0;
            disp_o.dots    <= DOTS_OFF;
        end
        else
        begin
            disp_o.valid   <= p1_valid_reg;
            disp_o.ram_sel <= p1_ram_reg;
            disp_o.dots    <= dots_next;
        end
    end

endmodule

`default_nettype wire

// *** test/glyph_ram_asserts.sv ***
// port checker for the user glyph pattern ram
`timescale 1ns/1ps
`default_nettype none

module glyph_ram_asserts
(
    input wire logic                         mclk_i,
    input wire logic                         rst_b_i,
    input wire glyph_pkg::font_e             font_i,
    input wire glyph_pkg::host_req_s         host_i,
    input wire glyph_pkg::host_rsp_s         host_o,
    input wire logic [glyph_pkg::ADDR_W-1:0] addr_o,
    input wire glyph_pkg::disp_req_s         disp_i,
    input wire glyph_pkg::disp_rsp_s         disp_o
);
    import glyph_pkg::*;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    logic up_reg; // step direction, up after reset

    // the counter hides its direction, so shadow it here
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            up_reg <= 1'b1;
        end
        else if (host_i.load)
        begin
            up_reg <= host_i.dir_up;
        end
    end

    sequence rd_take;
        host_i.rd && !host_i.wr && !host_i.load;
    endsequence
    sequence step_take;
        (host_i.wr || host_i.rd) && !host_i.load;
    endsequence
    sequence ram_fetch;
        disp_i.req && disp_i.code[7:4] == CODE_HI_RAM;
    endsequence

    ////////////////////////////////////////
    read_answer_a: assert property (rd_take |-> ##2 host_o.valid)
        else $error("read answer missing");
    valid_cause_a: assert property (host_o.valid |->
        $past(host_i.rd && !host_i.wr && !host_i.load, 2)) else $error("stray read answer");
    addr_step_a: assert property (step_take |=> addr_o ==
        (up_reg ? $past(addr_o) + ADDR_STEP : $past(addr_o) - ADDR_STEP))
        else $error("address did not step by one");
    addr_load_a: assert property (host_i.load |=> addr_o == $past(host_i.addr))
        else $error("start address not loaded");
    addr_hold_a: assert property (!(host_i.load || host_i.wr || host_i.rd) |=> $stable(addr_o))
        else $error("address moved while idle");
    ram_select_a: assert property (ram_fetch |-> ##2 disp_o.valid && disp_o.ram_sel)
        else $error("glyph ram not selected");
    rom_dark_a: assert property (disp_i.req && disp_i.code[7:4] != CODE_HI_RAM |->
        ##2 disp_o.valid && !disp_o.ram_sel && disp_o.dots == DOTS_OFF) else $error("rom code lit");
    cursor_or_a: assert property (ram_fetch ##0 (disp_i.cursor && (font_i == FONT_5X7 ?
        disp_i.row[2:0] == CURSOR_ROW_7 : disp_i.row == CURSOR_ROW_10)) |-> ##2
        disp_o.dots == DOTS_ALL) else $error("cursor not ored");
    hidden_row_a: assert property (disp_i.req && font_i == FONT_5X10 &&
        disp_i.row > LAST_ROW_10 |-> ##2 disp_o.dots == DOTS_OFF) else $error("hidden row lit");
endmodule

bind user_glyph_pattern_ram glyph_ram_asserts CHK
(
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .font_i  (font_i),
    .host_i  (host_i),
    .host_o  (host_o),
    .addr_o  (addr_o),
    .disp_i  (disp_i),
    .disp_o  (disp_o)
);

`default_nettype wire

// *** test/host_model.sv ***
// host microcontroller model issuing glyph ram row accesses
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    input  wire logic                 mclk_i,
    input  wire glyph_pkg::host_rsp_s rsp_i,
    output var  glyph_pkg::host_req_s req_o
);
    import glyph_pkg::*;

    initial req_o = '0;

    // a slow host leaves idle cycles; the idle bus keeps changing
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge mclk_i);
            req_o.data = ~req_o.data;
        end
    endtask

    // direction goes out with the start address, before any row
    task automatic load(input logic up, input logic [5:0] a);
        @(negedge mclk_i);
        req_o.load = 1'b1;
        req_o.dir_up = up;
        req_o.addr = a;
        @(negedge mclk_i);
        req_o.load = 1'b0;
        req_o.addr = ~a;
    endtask

    // one whole row per write; both strobes only when asked
    task automatic wr(input logic [7:0] d, input logic both);
        @(negedge mclk_i);
        req_o.wr = 1'b1;
        req_o.rd = both;
        req_o.data = d;
        @(negedge mclk_i);
        req_o.wr = 1'b0;
        req_o.rd = 1'b0;
        req_o.data = ~d;
    endtask

    // read one row; unknown comes back when no answer stood
    task automatic rd(output logic [7:0] d);
        @(negedge mclk_i);
        req_o.rd = 1'b1;
        @(negedge mclk_i);
        req_o.rd = 1'b0;
        @(negedge mclk_i);
        d = rsp_i.valid ? rsp_i.data : 'x;
    endtask
endmodule

`default_nettype wire

// *** test/user_glyph_pattern_ram_bench.sv ***
// self-checking bench for the user glyph pattern ram
`timescale 1ns/1ps
`default_nettype none

module user_glyph_pattern_ram_bench;
    import glyph_pkg::*;

    logic              mclk_i;
    logic              rst_b_i;
    font_e             font_i;
    host_req_s         host_i;
    host_rsp_s         host_o;
    logic [ADDR_W-1:0] addr_o;
    disp_req_s         disp_i;
    disp_rsp_s         disp_o;
    logic [7:0]        mem [64]; // expected contents
    int                bad_count;
    int                n_tests;
    int                cycles;
    integer            seed = 32'h8df42d87;

    user_glyph_pattern_ram DUT
    (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .font_i  (font_i),
        .host_i  (host_i),
        .host_o  (host_o),
        .addr_o  (addr_o),
        .disp_i  (disp_i),
        .disp_o  (disp_o)
    );

    host_model HOST
    (
        .mclk_i (mclk_i),
        .rsp_i  (host_o),
        .req_o  (host_i)
    );

    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // a hang ends the run well past the few thousand cycles needed
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            bad_count++;
            $display("Error %0t timeout", $time);
            end_sim;
        end
    end

    task automatic cmp_host(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t host got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_disp(input logic [6:0] got, input logic [6:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t dots got %h exp %h", $time, got, exp);
        end
    endtask

    // expected {ram_sel, dots} for one fetch
    function automatic logic [5:0] exp_disp(font_e f, logic [7:0] c, logic [3:0] r,
                                            logic cur);
        logic [4:0] d;
        if (c[7:4] != 4'h0)
            return 6'h00;
        if (f == FONT_5X7)
        begin
            d = mem[{c[2:0], r[2:0]}][4:0];
            if (cur && r[2:0] == 3'h7)
                d = d | 5'h1f;
        end
        else
        begin
            d = (r > 4'ha) ? 5'h00 : mem[{c[2:1], r}][4:0];
            if (cur && r == 4'ha)
                d = d | 5'h1f;
        end
        return {1'b1, d};
    endfunction

    // one fetch, answer looked at in the cycle it stands
    task automatic show(input font_e f, input logic [7:0] c, input logic [3:0] r,
                        input logic cur);
        @(negedge mclk_i);
        font_i = f;
        // plain concatenation keeps the packed struct load portable
        disp_i = {1'b1, c, r, cur};
        @(negedge mclk_i);
        disp_i.req = 1'b0;
        @(negedge mclk_i);
        cmp_disp({disp_o.valid, disp_o.ram_sel, disp_o.dots}, {1'b1, exp_disp(f, c, r, cur)});
    endtask

    ////////////////////////////////////////
    initial
    begin
        logic [5:0] a;
        logic [7:0] d;
        font_i = FONT_5X7;
        disp_i = '0;
        rst_b_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        rst_b_i = 1'b1;
        cmp_host({2'h0, addr_o}, 8'h00);
        // fill upward across the 63 to 0 wrap, random bits, bits 4:0 low on cursor rows
        HOST.load(1'b1, 6'h3e);
        for (int i = 0; i < 64; i++)
        begin
            a = 6'h3e + 6'(i);
            d = 8'($random(seed));
            if (a[2:0] == 3'h7 || a[3:0] == 4'ha)
                d[4:0] = 5'h00;
            mem[a] = d;
            HOST.wr(d, 1'b0);
            cmp_host({2'h0, addr_o}, {2'h0, a + 6'h01});
        end
        $display("fill done");
        // read back downward with a slow host
        HOST.load(1'b0, 6'h01);
        for (int i = 0; i < 64; i++)
        begin
            a = 6'h01 - 6'(i);
            HOST.idle($random(seed) & 3);
            HOST.rd(d);
            cmp_host(d, mem[a]);
            cmp_host({2'h0, addr_o}, {2'h0, a - 6'h01});
        end
        $display("readback done");
        // write and read together: write lands, one step, no answer
        HOST.load(1'b1, 6'h20);
        d = 8'($random(seed));
        mem[6'h20] = d;
        HOST.wr(d, 1'b1);
        cmp_host({2'h0, addr_o}, 8'h21);
        @(negedge mclk_i);
        cmp_host({7'h0, host_o.valid}, 8'h00);
        HOST.load(1'b1, 6'h20);
        HOST.rd(d);
        cmp_host(d, mem[6'h20]);
        $display("collision done");
        // every ram code against every row in both fonts
        for (int f = 0; f < 2; f++)
            for (int c = 0; c < 16; c++)
                for (int r = 0; r < 16; r++)
                    show(font_e'(f), 8'(c), 4'(r), 1'($random(seed)));
        $display("sweep done");
        // random codes, mostly from the rom side
        repeat (100)
            show(font_e'(1'($random(seed))), 8'($random(seed)), 4'($random(seed)),
                 1'($random(seed)));
        $display("random done");
        // reset in mid-run clears the counter and both answers, not the rows
        rst_b_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        rst_b_i = 1'b1;
        cmp_host({2'h0, addr_o}, 8'h00);
        cmp_host(host_o.data, 8'h00);
        cmp_disp({disp_o.valid, disp_o.ram_sel, disp_o.dots}, 7'h00);
        HOST.load(1'b1, 6'h20);
        HOST.rd(d);
        cmp_host(d, mem[6'h20]);
        $display("reset done");
        end_sim;
    end
endmodule

`default_nettype wire
